// File: foc_debug_override_regs.sv
// Debug override register bank: loop bypass, forced Vd/Vq, measurement control.
// Assumes a synchronous register port from the serial interface front end.
// Behaviour
// - 32-bit debug control at EEh, reset zero
// - Bypass bit 26 disables current/speed loops
// - Bits 25-16 give direct reference, over 500
// - Bits 15-6 give quadrature reference, over 500
// - Writing bit 5 starts parameter measurement
// - Bit 4 includes resistance step
// - Bit 3 includes inductance step
// - Bit 2 includes back-EMF step
// - Bit 1 includes mechanical step
// - Writing bit 0 commits measured parameters
// - Gain report at F0h, reset zero
// - Integral gain high half, proportional low
`timescale 1ns/1ps
module foc_debug_override_regs
    import foc_debug_pkg::*;
(
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_rst_n,
    input  wire foc_debug_pkg::reg_req_type   i_req,
    input  wire logic        [15:0]           i_current_integral_gain,
    input  wire logic        [15:0]           i_current_proportional_gain,
    output logic             [31:0]           o_rdata,
    output logic                              o_rvalid,
    output logic                              o_inner_loop_bypass,
    output logic signed      [10:0]           o_direct_voltage_reference,
    output logic signed      [10:0]           o_quadrature_voltage_reference,
    output logic                              o_param_measure_start,
    output foc_debug_pkg::measure_sel_type    o_measure_sel,
    output logic                              o_commit_measured_params
);
    import foc_debug_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_n;
    logic rst_n;

    // Two stages so release is clean against the clock
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [31:0]        control_debug_two;
    logic [31:0]        next_control_debug_two;
    logic [31:0]        active_current_gains;
    logic [31:0]        next_active_current_gains;
    logic [31:0]        next_rdata;
    logic               next_rvalid;
    logic               next_start;
    logic               next_commit;
    logic signed [10:0] vd_numer;
    logic signed [10:0] vq_numer;
    logic signed [10:0] next_vd;
    logic signed [10:0] next_vq;
    logic               wr_ctrl;
    logic               rd_gains;
    logic               next_bypass;
    measure_sel_type    next_sel;
    logic        [9:0]  axis_code  [2];
    logic signed [10:0] axis_numer [2];

    // Address decode; any other offset is ignored on write and reads zero
    assign wr_ctrl  = i_req.wr && (i_req.addr == control_debug_two_offset);
    assign rd_gains = i_req.rd && (i_req.addr == active_current_gains_offset);

    // Next stored values
    always_comb
    begin
        next_control_debug_two = control_debug_two;
        if (wr_ctrl)
            next_control_debug_two = i_req.wdata & writable_mask;
        next_active_current_gains = {i_current_integral_gain, i_current_proportional_gain};
    end

    // Reserved bits never load, so a wild write cannot set them
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_debug_two    <= control_debug_two_reset;
            active_current_gains <= active_current_gains_reset;
        end
        else
        begin
            control_debug_two    <= next_control_debug_two;
            active_current_gains <= next_active_current_gains;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command pulses

    // Pulses come from the write itself, not the store, so writing the
    // same command twice starts the routine twice
    always_comb
    begin
        next_start  = wr_ctrl && i_req.wdata[start_bit];
        next_commit = wr_ctrl && i_req.wdata[commit_bit];
    end

    // One-cycle pulses; a held level would restart the routine
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_param_measure_start    <= 1'b0;
            o_commit_measured_params <= 1'b0;
        end
        else
        begin
            o_param_measure_start    <= next_start;
            o_commit_measured_params <= next_commit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readback

    // Control fields are write-only and read as zero, so only the gain
    // report needs a path; its value lags the gain inputs by one cycle
    always_comb
    begin
        next_rvalid = i_req.rd;
        next_rdata  = '0;   // Unmapped and write-only reads give zero
        if (rd_gains)
            next_rdata = active_current_gains;
    end

    // Read data stands for the single cycle that rvalid does
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_rdata  <= '0;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rdata  <= next_rdata;
            o_rvalid <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Forced voltage references
    // direct axis code field
    assign axis_code[0] = control_debug_two[vd_msb:vd_lsb];
    assign axis_code[1] = control_debug_two[vq_msb:vq_lsb];

    // One code map per axis, since both fields share one signed mapping
    genvar axis;
    generate
        for (axis = 0; axis < 2; axis++)
        begin : g_axis_map
            voltage_code_map u_map (
                .i_code  (axis_code[axis]),
                .o_numer (axis_numer[axis])
            );
        end
    endgenerate

    // Named copies keep the gating below readable
    assign vd_numer = axis_numer[0];
    assign vq_numer = axis_numer[1];

    ////////////////////////////////////////////////////////////////////////////
    // Loop-facing outputs

    // Next output values; stored codes stay put while the loops run, but
    // re-enabling bypass takes a full write, so it applies the pair written with it
    always_comb
    begin
        next_bypass         = control_debug_two[bypass_bit];
        next_sel.resistance = control_debug_two[res_bit];
        next_sel.inductance = control_debug_two[ind_bit];
        next_sel.backemf    = control_debug_two[bemf_bit];
        next_sel.mechanical = control_debug_two[mech_bit];
        // References are numerators over 500; the loop scales them
        next_vd             = '0;
        next_vq             = '0;
        if (control_debug_two[bypass_bit])
        begin
            next_vd = vd_numer;
            next_vq = vq_numer;
        end
    end

    // Outputs registered to keep the loop inputs glitch free; bypass and
    // references move on the same edge, so the loop never sees them split
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_inner_loop_bypass            <= 1'b0;
            o_direct_voltage_reference     <= '0;
            o_quadrature_voltage_reference <= '0;
            o_measure_sel                  <= '0;
        end
        else
        begin
            o_inner_loop_bypass            <= next_bypass;
            o_direct_voltage_reference     <= next_vd;
            o_quadrature_voltage_reference <= next_vq;
            o_measure_sel                  <= next_sel;
        end
    end

endmodule : foc_debug_override_regs

// File: foc_debug_override_regs_sva.sv
// Checker for the debug override register bank, bound to its top module.
// Assumes requests start only once the reset synchronizer has let go.
`timescale 1ns/1ps
module foc_debug_override_regs_sva
    import foc_debug_pkg::*;
(
    input wire logic                         i_clk_sys,
    input wire logic                         i_rst_n,
    input wire foc_debug_pkg::reg_req_type   i_req,
    input wire logic        [15:0]           i_current_integral_gain,
    input wire logic        [15:0]           i_current_proportional_gain,
    input wire logic        [31:0]           o_rdata,
    input wire logic                         o_rvalid,
    input wire logic                         o_inner_loop_bypass,
    input wire logic signed [10:0]           o_direct_voltage_reference,
    input wire logic signed [10:0]           o_quadrature_voltage_reference,
    input wire logic                         o_param_measure_start,
    input wire foc_debug_pkg::measure_sel_type o_measure_sel,
    input wire logic                         o_commit_measured_params
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////
    // Decoded write and the two forced codes
    wire       w_ee = i_req.wr && (i_req.addr == control_debug_two_offset);
    wire [9:0] cd   = i_req.wdata[25:16];
    wire [9:0] cq   = i_req.wdata[15:6];
    function automatic logic [10:0] num(input logic [9:0] c);
        return (c > 10'd512) ? ({1'b0, c} - 11'h400) : {1'b0, c};
    endfunction : num
    // Pulses tie to the write one cycle back, so stray pulses fail too
    property p_start; o_param_measure_start == $past(w_ee && i_req.wdata[5]); endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");
    property p_commit; o_commit_measured_params == $past(w_ee && i_req.wdata[0]); endproperty
    a_commit: assert property (p_commit) else $error("commit pulse wrong");
    property p_bypass; w_ee |-> ##2 o_inner_loop_bypass == $past(i_req.wdata[26], 2); endproperty
    a_bypass: assert property (p_bypass) else $error("bypass level wrong");
    property p_sel; w_ee |-> ##2 o_measure_sel == $past(i_req.wdata[4:1], 2); endproperty
    a_sel: assert property (p_sel) else $error("step select wrong");
    property p_vd; w_ee && i_req.wdata[26] && (cd < 10'd500 || cd > 10'd512)
        |-> ##2 o_direct_voltage_reference == num($past(cd, 2)); endproperty
    a_vd: assert property (p_vd) else $error("direct reference wrong");
    property p_vq; w_ee && i_req.wdata[26] && (cq < 10'd500 || cq > 10'd512)
        |-> ##2 o_quadrature_voltage_reference == num($past(cq, 2)); endproperty
    a_vq: assert property (p_vq) else $error("quadrature reference wrong");
    property p_idle; !o_inner_loop_bypass |-> (o_direct_voltage_reference == 11'sd0)
        && (o_quadrature_voltage_reference == 11'sd0); endproperty
    a_idle: assert property (p_idle) else $error("reference without bypass");
    property p_gain; i_req.rd && (i_req.addr == active_current_gains_offset) |=> o_rvalid
        && o_rdata == {$past(i_current_integral_gain, 2), $past(i_current_proportional_gain, 2)};
    endproperty
    a_gain: assert property (p_gain) else $error("gain readback wrong");
endmodule : foc_debug_override_regs_sva
bind foc_debug_override_regs foc_debug_override_regs_sva u_sva (.*);

// File: foc_debug_pkg.sv
// Package for the loop debug override register bank.
// Assumes a simple synchronous register port driven by the serial front end.
package foc_debug_pkg;

    localparam logic [7:0]  control_debug_two_offset    = 8'hee;
    localparam logic [7:0]  active_current_gains_offset = 8'hf0;
    localparam logic [31:0] control_debug_two_reset     = 32'h00000000;
    localparam logic [31:0] active_current_gains_reset  = 32'h00000000;

    // Field positions of control_debug_two
    localparam int bypass_bit      = 26;
    localparam int vd_msb          = 25;
    localparam int vd_lsb          = 16;
    localparam int vq_msb          = 15;
    localparam int vq_lsb          = 6;
    localparam int start_bit       = 5;
    localparam int res_bit         = 4;
    localparam int ind_bit         = 3;
    localparam int bemf_bit        = 2;
    localparam int mech_bit        = 1;
    localparam int commit_bit      = 0;
    localparam logic [31:0] writable_mask = 32'h07ffffdf;

    // Gain report layout
    localparam int ki_lsb = 16;
    localparam int kp_lsb = 0;

    // Forced voltage code thresholds
    localparam logic [9:0] code_pos_limit = 10'h1f4;  // 500
    localparam logic [9:0] code_neg_floor = 10'h200;  // 512

    // Register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_type;

    // Measurement step selection
    typedef struct packed {
        logic resistance;
        logic inductance;
        logic backemf;
        logic mechanical;
    } measure_sel_type;

endpackage : foc_debug_pkg

// File: testbench.sv
// Self-checking bench for the debug override register bank.
// Assumes the bound checker is compiled alongside the design.
`timescale 1ns/1ps
module testbench;
    import foc_debug_pkg::*;
    logic               clk_sys = 1'b0;
    logic               rst_n   = 1'b0;
    reg_req_type        req     = '0;
    logic        [15:0] ki      = '0;
    logic        [15:0] kp      = '0;
    logic        [31:0] rdata;
    logic               rvalid, bypass, start, commit;
    logic signed [10:0] vd_ref, vq_ref;
    measure_sel_type    sel;
    int                 errors  = 0;
    int                 n_tests = 0;
    // forced codes all inside the valid ranges
    logic        [9:0]  codes [5] = '{10'd0, 10'd499, 10'd500, 10'd513, 10'd1000};
    foc_debug_override_regs dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_req(req),
        .i_current_integral_gain(ki), .i_current_proportional_gain(kp), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_inner_loop_bypass(bypass), .o_direct_voltage_reference(vd_ref),
        .o_quadrature_voltage_reference(vq_ref), .o_param_measure_start(start),
        .o_measure_sel(sel), .o_commit_measured_params(commit));
    ////////////////////////////////////////////////////////////
    // Clock, and a watchdog far beyond the sixty or so cycles needed
    initial forever #4 clk_sys = ~clk_sys;
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        errors++;
        summarize();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Expected signed numerator, sign extended to the compare width
    function automatic logic [31:0] ex(input logic [9:0] c);
        return (c > 10'd512) ? 32'(c) - 32'h400 : 32'(c);
    endfunction : ex
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys) req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys) req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk_sys) req <= '0;
        // Answer stands for one cycle after the taking edge
        #1;
        chk({31'h0, rvalid}, 32'h1);
        chk(rdata, exp);
    endtask : rd
    // Levels land one edge after the taking edge
    task automatic lv;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : lv
    task automatic t_force;
        for (int i = 0; i < 5; i++)
        begin
            wr(8'hee, {5'h0, 1'b1, codes[i], codes[4-i], 6'h0});
            lv();
            chk({31'h0, bypass}, 32'h1);
            chk(vd_ref, ex(codes[i]));
            chk(vq_ref, ex(codes[4-i]));
        end
        wr(8'hee, {5'h0, 1'b0, 10'd499, 10'd600, 6'h0});
        lv();
        chk({bypass, vd_ref, vq_ref}, 32'h0);
        $display("test force done");
    endtask : t_force
    task automatic t_measure;
        for (int k = 0; k < 4; k++)
        begin
            wr(8'hee, (32'h2 << k) | 32'h21);
            // Pulses stand only until the next edge
            #1;
            chk({start, commit}, 32'h3);
            @(posedge clk_sys) #1;
            chk({start, commit, sel}, 32'h1 << k);
        end
        wr(8'hf0, 32'h21);
        #1;
        chk({start, commit}, 32'h0);
        rd(8'hee, 32'h0);
        $display("test measure done");
    endtask : t_measure
    task automatic t_gains;
        chk({bypass, vd_ref, vq_ref, start, commit, sel, rvalid}, 32'h0);
        rd(8'hf0, 32'h0);
        @(posedge clk_sys) ki <= 16'ha5c3;
        kp <= 16'h0f1e;
        rd(8'hf0, 32'ha5c30f1e);
        rd(8'hef, 32'h0);
        $display("test gains done");
    endtask : t_gains
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    // Reset for six cycles, then let the synchronizer settle
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_gains();
        t_force();
        t_measure();
        summarize();
    end
endmodule : testbench

// File: voltage_code_map.sv
// Maps a 10-bit forced voltage code to a signed reference numerator.
// Assumes software keeps codes in the valid ranges; others map to zero.
`timescale 1ns/1ps
module voltage_code_map
    import foc_debug_pkg::*;
(
    input  wire logic        [9:0]  i_code,
    output logic signed      [10:0] o_numer
);

    // Codes up to 500 stand as is, above 512 are code minus 1024
    always_comb
    begin
        if (i_code <= code_pos_limit)
            o_numer = signed'({1'b0, i_code});
        else if (i_code > code_neg_floor)
            o_numer = signed'({1'b1, i_code});
        else
            o_numer = '0;   // Gap codes are not valid settings
    end

endmodule : voltage_code_map
